// [bench/sync_hold_power_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_hold_power_control_test;
  logic        ref_clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        line_s, green_s, frame_s, hold_in;
  logic [2:0]  src_en;
  logic        pll_line_ref, pll_hold, red_mid, blue_mid;
  logic [4:0]  slicer_level;
  logic        power_down, seek_mode, line_oe, frame_oe, green_oe;
  logic [1:0]  dck_oe;
  logic [47:0] data_oe;
  int          miscompares, n_checks, cycles;
  logic [7:0]  v, seed_v;
  logic        l, g, ovr, sel, active_line_sync_source, prev;
  logic        f0, f1;
  int          hold_n, frame_n;

  sync_hold_power_control #(.ACT_WINDOW(16), .DATA_OUTS(48)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_sync_in(line_s),
    .green_sync_in(green_s), .frame_sync_in(frame_s), .hold_in(hold_in),
    .pll_line_ref(pll_line_ref), .pll_hold(pll_hold), .slicer_level(slicer_level),
    .red_clamp_mid(red_mid), .blue_clamp_mid(blue_mid), .power_down(power_down),
    .seek_mode(seek_mode), .line_sync_output_oe(line_oe), .frame_sync_output_oe(frame_oe),
    .data_clock_output_oe(dck_oe), .data_out_oe(data_oe), .green_sync_output_oe(green_oe));

  sync_source src_u (
    .ref_clk(ref_clk), .reset(reset), .en(src_en),
    .line_sync(line_s), .green_sync(green_s), .frame_sync(frame_s));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  // all output enables folded into one byte; a partly driven data bus shows as x
  function automatic logic [7:0] oe_pack();
    logic d;
    d = (data_oe === '1) ? 1'b1 : ((data_oe === '0) ? 1'b0 : 1'bx);
    return {2'b00, line_oe, frame_oe, dck_oe, d, green_oe};
  endfunction : oe_pack

  function automatic logic exp_ahs(input logic l, g, ovr, sel);
    return (ovr || l == g) ? sel : g;
  endfunction : exp_ahs

  localparam logic [7:0] ADDRS [6] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13};
  localparam logic [7:0] RSTS  [6] = '{8'h40, 8'h4e, 8'h78, 8'h20, 8'h00, 8'h00};

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hold_in = 1'b0;
    src_en = 3'b000;
    seed_v = 8'($urandom(32'hc9a6));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    wait_cyc(2);
    chk({3'b000, slicer_level}, 8'h0f, "slicer reset");
    chk(oe_pack(), 8'h3f, "oe after reset");
    for (int i = 0; i < 6; i++) begin
      rd(ADDRS[i], v);
      chk(v, RSTS[i], "reset value");
    end
    wait_cyc(60);
    rd(8'h14, v);
    chk(v & 8'hfe, 8'h08, "quiet status");
    chk({7'h0, seek_mode}, 8'h01, "seek allowed");
    wr(8'h0f, 8'h4a);
    wait_cyc(3);
    chk({7'h0, seek_mode}, 8'h00, "seek forbidden");
    for (int i = 0; i < 9; i++) begin
      v = 8'($urandom);
      wr(8'h11 + 8'(i % 3), v);
      rd(8'h11 + 8'(i % 3), seed_v);
      chk(seed_v, v, "plain register");
    end
    wr(8'h11, 8'h20);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : ((i == 1) ? 8'hff : 8'($urandom));
      wr(8'h10, v);
      wait_cyc(2);
      chk({3'b000, slicer_level}, {3'b000, v[7:3]}, "slicer level");
      chk({6'h0, red_mid, blue_mid}, {6'h0, v[2:1]}, "clamp target");
      rd(8'h10, seed_v);
      chk(seed_v, v & 8'hfe, "slicer readback");
    end
    wr(8'h20, 8'hff);
    rd(8'h20, v);
    chk(v, 8'h00, "unmapped read");
    wr(8'h14, 8'hff);
    rd(8'h14, v);
    chk(v & 8'hfe, 8'h08, "status write ignored");
    wr(8'h0f, 8'h5e);
    for (int k = 0; k < 16; k++) begin
      {l, g, ovr, sel} = 4'(k);
      active_line_sync_source = exp_ahs(l, g, ovr, sel);
      src_en <= {1'b0, g, l};
      wr(8'h0e, 8'h40 | {3'b000, ovr, sel, 3'b000});
      wait_cyc(60);
      rd(8'h14, v);
      chk(v & 8'hfe, {l, active_line_sync_source, 2'b00, 1'b1, 1'b0, g, 1'b0}, "detect");
      prev = active_line_sync_source ? green_s : line_s;
      repeat (20) begin
        @(posedge ref_clk);
        #1;
        chk({7'h0, pll_line_ref}, {7'h0, prev}, "pll reference");
        prev = active_line_sync_source ? green_s : line_s;
      end
    end
    src_en <= 3'b001;
    wr(8'h0e, 8'h40);
    hold_in <= 1'b1;
    wait_cyc(3);
    chk({7'h0, pll_hold}, 8'h01, "hold active high");
    repeat (8) begin
      wait_cyc(1);
      chk({7'h0, pll_line_ref}, 8'h00, "line masked by hold");
    end
    wr(8'h0f, 8'h56);
    wait_cyc(3);
    chk({7'h0, pll_hold}, 8'h00, "hold high ignored");
    hold_in <= 1'b0;
    wait_cyc(3);
    chk({7'h0, pll_hold}, 8'h01, "hold active low");
    // user polarity 0 without override: detected polarity must win
    wr(8'h0f, 8'h46);
    wait_cyc(40);
    chk({7'h0, pll_hold}, 8'h00, "detected polarity");
    wr(8'h0e, 8'h42);
    wr(8'h0f, 8'h7e);
    hold_in <= 1'b1;
    wait_cyc(6);
    chk({7'h0, pll_hold}, 8'h00, "hold pin not routed");
    // frame pin as hold source, no pre or post window: hold lags the pin two cycles
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h00);
    src_en <= 3'b101;
    wait_cyc(40);
    rd(8'h14, v);
    chk(v & 8'h18, 8'h10, "frame detect");
    f1 = frame_s;
    wait_cyc(1);
    f0 = frame_s;
    repeat (40) begin
      wait_cyc(1);
      chk({7'h0, pll_hold}, {7'h0, f1}, "hold follows frame");
      f1 = f0;
      f0 = frame_s;
    end
    // one post line: every frame end keeps hold up until the next line edge
    wr(8'h13, 8'h01);
    wait_cyc(14);
    hold_n = 0;
    frame_n = 0;
    repeat (70) begin
      wait_cyc(1);
      hold_n += int'(pll_hold);
      frame_n += int'(frame_s);
    end
    chk({7'h0, hold_n > frame_n + 3}, 8'h01, "post hold extends");
    // separator as frame source; green sits still, so its output settles inverted
    wr(8'h0e, 8'h43);
    wr(8'h11, 8'h04);
    wait_cyc(300);
    chk({7'h0, pll_hold}, {7'h0, ~green_s}, "separator frame");
    wr(8'h11, 8'h20);
    hold_in <= 1'b0;
    wr(8'h0f, 8'h4c);
    wait_cyc(3);
    chk({7'h0, power_down}, 8'h01, "power down");
    chk(oe_pack(), 8'h01, "oe in power down");
    rd(8'h0f, v);
    chk(v, 8'h4c, "register in power down");
    rd(8'h14, v);
    chk(v & 8'h80, 8'h80, "detect in power down");
    wr(8'h0f, 8'h4e);
    wait_cyc(3);
    chk(oe_pack(), 8'h3f, "oe restored");
    finish_test();
  end
endmodule : sync_hold_power_control_test
`default_nettype wire

// [bench/sync_source.sv]
`timescale 1ns/1ps
`default_nettype none
// graphics source: an enabled line toggles at its own half period
// a disabled line sits still at its last level, which must read as inactive
module sync_source #(
  parameter int LINE_HALF  = 3,
  parameter int GREEN_HALF = 5,
  parameter int FRAME_HALF = 7
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // enables: bit 0 line, bit 1 green, bit 2 frame
  input  wire logic [2:0] en,
  // sync lines
  output var  logic       line_sync,
  output var  logic       green_sync,
  output var  logic       frame_sync
);
  int cnt_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r      <= 0;
      line_sync  <= 1'b0;
      green_sync <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1;
      if (en[0] && (cnt_r % LINE_HALF) == 0) line_sync <= ~line_sync;
      if (en[1] && (cnt_r % GREEN_HALF) == 0) green_sync <= ~green_sync;
      if (en[2] && (cnt_r % FRAME_HALF) == 0) frame_sync <= ~frame_sync;
    end
  end
endmodule : sync_source
`default_nettype wire

// [core/activity_detect.sv]
`timescale 1ns/1ps
`default_nettype none
// reports whether the input toggled at least once in the last full window
module activity_detect #(
  parameter int WINDOW = 65536
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // line
  input  wire logic sync_in,
  output var  logic active
);
  localparam int CW = $clog2(WINDOW);
  logic [CW-1:0] win_cnt_r;
  logic          prev_r;
  logic          seen_r;
  logic          win_end;

  assign win_end = (win_cnt_r == CW'(WINDOW - 1));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      win_cnt_r <= '0;
    end else if (win_end) begin
      win_cnt_r <= '0;
    end else begin
      win_cnt_r <= win_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sync_in;
    end
  end

  // an edge in the closing cycle still counts for the next window
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seen_r <= 1'b0;
      active <= 1'b0;
    end else begin
      if (win_end) begin
        active <= seen_r | (sync_in ^ prev_r);
      end
      seen_r <= (sync_in ^ prev_r) | (seen_r & ~win_end);
    end
  end
endmodule : activity_detect
`default_nettype wire

// [core/sync_hold_defs.svh]
`ifndef SYNC_HOLD_DEFS_SVH
`define SYNC_HOLD_DEFS_SVH

// register addresses
`define ADDR_SYNC_CTRL  8'h0e
`define ADDR_HOLD_PWR   8'h0f
`define ADDR_SLICER     8'h10
`define ADDR_SEP_THR    8'h11
`define ADDR_PRE_HOLD   8'h12
`define ADDR_POST_HOLD  8'h13
`define ADDR_STATUS     8'h14

// sync control fields
`define B_VS_SEL        0
`define B_VS_OVR        1
`define B_HS_SEL        3
`define B_HS_OVR        4

// hold and power fields
`define B_PWR_ON        1
`define B_SEEK          2
`define B_HOLD_POL      3
`define B_HOLD_OVR      4
`define B_HOLD_SRC      5

// slicer and clamp fields
`define B_BLUE_MID      1
`define B_RED_MID       2
`define SLICER_MSB      7
`define SLICER_LSB      3

// status fields
`define B_ST_HOLD_POL   0
`define B_ST_SOG_DET    1
`define B_ST_AVS        3
`define B_ST_VS_DET     4
`define B_ST_AHS        6
`define B_ST_HS_DET     7

// reset values
`define RST_SYNC_CTRL   8'h40
`define RST_HOLD_PWR    8'h4e
`define RST_SLICER      8'h78
`define RST_SEP_THR     8'h20
`define RST_PRE_HOLD    8'h00
`define RST_POST_HOLD   8'h00
`define RD_UNMAPPED     8'h00

// timing
`define CLK_PERIOD_NS   5
`define SEP_PERIOD_NS   200
`define SEP_DIV         (`SEP_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [core/sync_hold_pkg.sv]
package sync_hold_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum {HOLD_IDLE, HOLD_PRE, HOLD_FRAME, HOLD_POST} hold_phase_e;
endpackage : sync_hold_pkg

// [core/sync_hold_power_control.sv]
// How it works
// - hold source bit picks hold pin or frame
// - polarity override picks detected or user polarity
// - active hold masks line sync to the PLL
// - user hold polarity only used under override
// - seek bit allows low-power seek with no sync
// - power bit 0 powers down, resets to 1
// - power-down releases outputs, green sync stays driven
// - sync logic and registers keep running in power-down
// - slicer threshold field bits 7-3, reset 15
// - red clamp target select, bit 2
// - blue clamp target select, bit 1
// - separator toggles after counting threshold ticks
// - pre-hold asserts hold lines before frame sync
// - post-hold keeps hold lines after frame sync
// - status bit 7 reports line sync pin activity
// - active source auto-selects, else user select
// - PLL line reference follows active source bit
// - status bit 1 reports green sync activity
// - user select used under override, or when both or neither are active
// - frame sync select under override: pin or separator
`timescale 1ns/1ps
`default_nettype none
`include "sync_hold_defs.svh"
module sync_hold_power_control #(
  parameter int ACT_WINDOW = 65536,
  parameter int DATA_OUTS  = 48
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [7:0]           reg_rdata,
  // sync inputs
  input  wire logic                 line_sync_in,
  input  wire logic                 green_sync_in,
  input  wire logic                 frame_sync_in,
  input  wire logic                 hold_in,
  // PLL side
  output var  logic                 pll_line_ref,
  output var  logic                 pll_hold,
  // analog controls
  output var  logic [4:0]           slicer_level,
  output var  logic                 red_clamp_mid,
  output var  logic                 blue_clamp_mid,
  // power
  output var  logic                 power_down,
  output var  logic                 seek_mode,
  output var  logic                 line_sync_output_oe,
  output var  logic                 frame_sync_output_oe,
  output var  logic [1:0]           data_clock_output_oe,
  output var  logic [DATA_OUTS-1:0] data_out_oe,
  output var  logic                 green_sync_output_oe
);
  sync_hold_pkg::reg_byte_t sync_ctrl_r;
  sync_hold_pkg::reg_byte_t hold_pwr_r;
  sync_hold_pkg::reg_byte_t slicer_r;
  sync_hold_pkg::reg_byte_t sep_thr_r;
  sync_hold_pkg::reg_byte_t pre_hold_r;
  sync_hold_pkg::reg_byte_t post_hold_r;
  sync_hold_pkg::reg_byte_t status;
  sync_hold_pkg::hold_phase_e phase_r;
  sync_hold_pkg::hold_phase_e phase_nxt;

  logic [2:0] act;
  logic       hs_act;
  logic       sog_act;
  logic       vs_act;
  logic       sep_frame;
  logic       ahs_r;
  logic       ahs_nxt;
  logic       avs_r;
  logic       line_sel;
  logic       line_prev_r;
  logic       line_edge;
  logic       frame_sel;
  logic       frame_prev_r;
  logic       frame_rise;
  logic       frame_fall;
  logic       hold_idle_r;
  logic       hold_pol;
  logic       pin_hold;
  logic       win_hold;
  logic       hold_active;
  logic [7:0] line_cnt_r;
  logic [7:0] frame_lines_r;
  logic [7:0] post_cnt_r;
  logic       pre_due;

  // ---------------- register file
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync_ctrl_r <= `RST_SYNC_CTRL;
      hold_pwr_r  <= `RST_HOLD_PWR;
      slicer_r    <= `RST_SLICER;
      sep_thr_r   <= `RST_SEP_THR;
      pre_hold_r  <= `RST_PRE_HOLD;
      post_hold_r <= `RST_POST_HOLD;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_SYNC_CTRL: sync_ctrl_r <= reg_wdata;
        `ADDR_HOLD_PWR:  hold_pwr_r  <= reg_wdata;
        `ADDR_SLICER:    slicer_r    <= {reg_wdata[7:1], 1'b0};
        `ADDR_SEP_THR:   sep_thr_r   <= reg_wdata;
        `ADDR_PRE_HOLD:  pre_hold_r  <= reg_wdata;
        `ADDR_POST_HOLD: post_hold_r <= reg_wdata;
        default: ; // status and unmapped writes are dropped
      endcase
    end
  end

  // live status, never stored from the bus
  always_comb begin
    status                = '0;
    status[`B_ST_HS_DET]  = hs_act;
    status[`B_ST_AHS]     = ahs_r;
    status[`B_ST_VS_DET]  = vs_act;
    status[`B_ST_AVS]     = avs_r;
    status[`B_ST_SOG_DET] = sog_act;
    status[`B_ST_HOLD_POL] = ~hold_idle_r;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= `RD_UNMAPPED;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_SYNC_CTRL: reg_rdata <= sync_ctrl_r;
        `ADDR_HOLD_PWR:  reg_rdata <= hold_pwr_r;
        `ADDR_SLICER:    reg_rdata <= slicer_r;
        `ADDR_SEP_THR:   reg_rdata <= sep_thr_r;
        `ADDR_PRE_HOLD:  reg_rdata <= pre_hold_r;
        `ADDR_POST_HOLD: reg_rdata <= post_hold_r;
        `ADDR_STATUS:    reg_rdata <= status;
        default:         reg_rdata <= `RD_UNMAPPED;
      endcase
    end
  end

  // activity detection (runs in power-down too)
  logic [2:0] act_in;
  assign act_in = {frame_sync_in, green_sync_in, line_sync_in};

  for (genvar i = 0; i < 3; i++) begin : g_act
    activity_detect #(
      .WINDOW (ACT_WINDOW)
    ) u_act (
      .ref_clk (ref_clk),
      .reset   (reset),
      .sync_in (act_in[i]),
      .active  (act[i])
    );
  end

  assign hs_act  = act[0];
  assign sog_act = act[1];
  assign vs_act  = act[2];

  sync_separator u_sep (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .threshold (sep_thr_r),
    .comp_sync (green_sync_in),
    .frame_out (sep_frame)
  );

  // ---------------- source selection
  always_comb begin
    if (sync_ctrl_r[`B_HS_OVR] || (hs_act == sog_act)) begin
      ahs_nxt = sync_ctrl_r[`B_HS_SEL];
    end else begin
      ahs_nxt = sog_act;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ahs_r <= 1'b0;
      avs_r <= 1'b0;
    end else begin
      ahs_r <= ahs_nxt;
      avs_r <= sync_ctrl_r[`B_VS_OVR] ? sync_ctrl_r[`B_VS_SEL] : ~vs_act;
    end
  end

  assign line_sel  = ahs_r ? green_sync_in : line_sync_in;
  assign frame_sel = avs_r ? sep_frame : frame_sync_in;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      line_prev_r  <= 1'b0;
      frame_prev_r <= 1'b0;
    end else begin
      line_prev_r  <= line_sel;
      frame_prev_r <= frame_sel;
    end
  end

  assign line_edge  = line_sel & ~line_prev_r;
  assign frame_rise = frame_sel & ~frame_prev_r;
  assign frame_fall = ~frame_sel & frame_prev_r;

  // ---------------- hold pin polarity
  // idle level sampled at line edges; hold pulses are rare against lines
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hold_idle_r <= 1'b0;
    end else if (line_edge) begin
      hold_idle_r <= hold_in;
    end
  end

  // user polarity is ignored unless the override is set
  assign hold_pol = hold_pwr_r[`B_HOLD_OVR] ? hold_pwr_r[`B_HOLD_POL] : ~hold_idle_r;
  assign pin_hold = (hold_in == hold_pol);

  // ---------------- line counting for pre/post windows
  // pre-hold predicts the next frame from the length of the last one
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      line_cnt_r    <= '0;
      frame_lines_r <= '0;
    end else if (frame_rise) begin
      line_cnt_r    <= '0;
      frame_lines_r <= line_cnt_r;
    end else if (line_edge && line_cnt_r != 8'hff) begin
      line_cnt_r <= line_cnt_r + 1'b1;
    end
  end

  assign pre_due = (pre_hold_r != '0) && (frame_lines_r != '0)
                   && ({1'b0, line_cnt_r} + {1'b0, pre_hold_r} >= {1'b0, frame_lines_r});

  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      sync_hold_pkg::HOLD_IDLE: begin
        if (frame_sel) begin
          phase_nxt = sync_hold_pkg::HOLD_FRAME;
        end else if (pre_due) begin
          phase_nxt = sync_hold_pkg::HOLD_PRE;
        end
      end
      sync_hold_pkg::HOLD_PRE: begin
        if (frame_sel) begin
          phase_nxt = sync_hold_pkg::HOLD_FRAME;
        end
      end
      sync_hold_pkg::HOLD_FRAME: begin
        if (frame_fall) begin
          phase_nxt = (post_hold_r != '0) ? sync_hold_pkg::HOLD_POST
                                          : sync_hold_pkg::HOLD_IDLE;
        end
      end
      sync_hold_pkg::HOLD_POST: begin
        if (frame_sel) begin
          phase_nxt = sync_hold_pkg::HOLD_FRAME;
        end else if (line_edge && post_cnt_r + 1'b1 >= post_hold_r) begin
          phase_nxt = sync_hold_pkg::HOLD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_r <= sync_hold_pkg::HOLD_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      post_cnt_r <= '0;
    end else if (phase_r != sync_hold_pkg::HOLD_POST) begin
      post_cnt_r <= '0;
    end else if (line_edge) begin
      post_cnt_r <= post_cnt_r + 1'b1;
    end
  end

  assign win_hold    = (phase_r != sync_hold_pkg::HOLD_IDLE);
  assign hold_active = hold_pwr_r[`B_HOLD_SRC] ? win_hold : pin_hold;

  // ---------------- PLL side
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pll_hold     <= 1'b0;
      pll_line_ref <= 1'b0;
    end else begin
      pll_hold     <= hold_active;
      pll_line_ref <= line_sel & ~hold_active;
    end
  end

  // ---------------- analog controls
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      slicer_level   <= '0;
      red_clamp_mid  <= 1'b0;
      blue_clamp_mid <= 1'b0;
    end else begin
      slicer_level   <= slicer_r[`SLICER_MSB:`SLICER_LSB];
      red_clamp_mid  <= slicer_r[`B_RED_MID];
      blue_clamp_mid <= slicer_r[`B_BLUE_MID];
    end
  end

  // ---------------- power and seek
  // only output drivers drop in power-down; sensing stays alive for restart
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      power_down           <= 1'b0;
      seek_mode            <= 1'b0;
      line_sync_output_oe  <= 1'b0;
      frame_sync_output_oe <= 1'b0;
      data_clock_output_oe <= '0;
      data_out_oe          <= '0;
      green_sync_output_oe <= 1'b1;
    end else begin
      power_down           <= ~hold_pwr_r[`B_PWR_ON];
      seek_mode            <= hold_pwr_r[`B_SEEK] & ~(|act);
      line_sync_output_oe  <= hold_pwr_r[`B_PWR_ON];
      frame_sync_output_oe <= hold_pwr_r[`B_PWR_ON];
      data_clock_output_oe <= {2{hold_pwr_r[`B_PWR_ON]}};
      data_out_oe          <= {DATA_OUTS{hold_pwr_r[`B_PWR_ON]}};
      green_sync_output_oe <= 1'b1;
    end
  end

  // ---------------- checks
  pwr_tristate_a: assert property (@(posedge ref_clk) disable iff (reset)
    !hold_pwr_r[`B_PWR_ON] |=> data_out_oe == '0 && data_clock_output_oe == '0
                               && !line_sync_output_oe && power_down)
    else $error("outputs still enabled in power-down");

  green_drive_a: assert property (@(posedge ref_clk) disable iff (reset)
    power_down |-> green_sync_output_oe)
    else $error("green sync output released");

  ahs_auto_a: assert property (@(posedge ref_clk) disable iff (reset)
    !sync_ctrl_r[`B_HS_OVR] && hs_act && !sog_act |=> !ahs_r)
    else $error("auto select did not pick line pin");

  ahs_ovr_a: assert property (@(posedge ref_clk) disable iff (reset)
    sync_ctrl_r[`B_HS_OVR] |=> ahs_r == $past(sync_ctrl_r[`B_HS_SEL]))
    else $error("override select not honoured");

  hold_mask_a: assert property (@(posedge ref_clk) disable iff (reset)
    hold_active |=> pll_hold && !pll_line_ref)
    else $error("line sync passed during hold");

  pll_src_a: assert property (@(posedge ref_clk) disable iff (reset)
    ahs_r && !hold_active |=> pll_line_ref == $past(green_sync_in))
    else $error("pll reference not from green sync");

  status_ro_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_wr && reg_addr == `ADDR_STATUS |=> $stable(hold_pwr_r) && $stable(sync_ctrl_r))
    else $error("write to status changed a register");

  seek_block_a: assert property (@(posedge ref_clk) disable iff (reset)
    !hold_pwr_r[`B_SEEK] |=> !seek_mode)
    else $error("seek mode entered while forbidden");

  pin_pol_a: assert property (@(posedge ref_clk) disable iff (reset)
    !hold_pwr_r[`B_HOLD_SRC] && hold_pwr_r[`B_HOLD_OVR] |=>
      pll_hold == ($past(hold_in) == $past(hold_pwr_r[`B_HOLD_POL])))
    else $error("hold pin polarity not user value");

  pre_hold_c: cover property (@(posedge ref_clk) disable iff (reset)
    phase_r == sync_hold_pkg::HOLD_PRE ##1 phase_r == sync_hold_pkg::HOLD_FRAME);
  post_hold_c: cover property (@(posedge ref_clk) disable iff (reset)
    phase_r == sync_hold_pkg::HOLD_POST ##1 phase_r == sync_hold_pkg::HOLD_IDLE);
  power_down_c: cover property (@(posedge ref_clk) disable iff (reset) power_down);
  auto_green_c: cover property (@(posedge ref_clk) disable iff (reset)
    !sync_ctrl_r[`B_HS_OVR] && ahs_r);
endmodule : sync_hold_power_control
`default_nettype wire

// [core/sync_separator.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sync_hold_defs.svh"
// slow low-pass on composite sync: line pulses are too short to flip it
module sync_separator (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // control
  input  wire logic [7:0] threshold,
  // line
  input  wire logic       comp_sync,
  output var  logic       frame_out
);
  logic [5:0] div_r;
  logic       tick;
  logic [7:0] cnt_r;

  assign tick = (div_r == 6'(`SEP_DIV - 1));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // composite sync taken active low; frame_out is active high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r     <= '0;
      frame_out <= 1'b0;
    end else if (comp_sync != frame_out) begin
      cnt_r <= '0;
    end else if (tick) begin
      if (cnt_r >= threshold) begin
        cnt_r     <= '0;
        frame_out <= ~frame_out;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  sep_toggle_a: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(frame_out) |-> $past(tick) && $past(cnt_r) >= $past(threshold))
    else $error("separator toggled before threshold");
endmodule : sync_separator
`default_nettype wire
